//--- hdl/canmb_top.sv
// Receive filtering and buffering plus prioritised transmit queue for a CAN controller.
`timescale 1ns/1ns
module canmb_top (
   input  wire logic                                i_clk,
   input  wire logic                                i_rst,
   input  wire logic                                i_init_mode,
   // Assembly buffer hand-off from the protocol engine.
   input  wire logic                                i_asm_valid,
   input  wire canmb_pkg::canmb_msg_t               i_asm_msg,
   output logic                                     o_asm_ready,
   input  wire logic                                i_rx_crc_err,
   input  wire logic                                i_rx_stuff_err,
   input  wire logic                                i_rx_invalid_err,
   input  wire logic                                i_wake_bus,
   input  wire logic                                i_wake_sleep,
   // Acceptance configuration.
   input  wire canmb_pkg::canmb_filt_t [5:0]        i_accept_filter,
   input  wire logic [1:0][28:0]                    i_accept_mask,
   input  wire logic [1:0][1:0]                     i_reception_mode_field,
   input  wire logic                                i_double_buffer_enable,
   input  wire logic [1:0]                          i_message_received_irq_enable,
   input  wire logic                                i_send_irq_enable,
   input  wire logic                                i_error_irq_enable,
   input  wire logic                                i_wake_irq_enable,
   input  wire logic [15:0]                         i_status_clear,
   // Transmit buffers.
   input  wire logic [2:0]                          i_tx_load,
   input  wire canmb_pkg::canmb_msg_t               i_tx_msg,
   input  wire logic [2:0][1:0]                     i_send_priority_field,
   input  wire logic [2:0]                          i_send_request_set,
   input  wire logic [2:0]                          i_send_request_clear,
   input  wire logic                                i_abort_all_pending,
   input  wire logic                                i_bus_idle,
   input  wire logic                                i_tx_success,
   input  wire logic                                i_tx_lost,
   input  wire logic                                i_tx_bus_err,
   input  wire logic                                i_tx_ack_err,
   input  wire logic                                i_tx_form_err,
   input  wire logic                                i_tx_bit_err,
   input  wire logic                                i_bus_off_recover,
   output canmb_pkg::canmb_msg_t                    o_tx_msg,
   output logic                                     o_tx_start,
   output logic                                     o_tx_drive_en,
   output logic [2:0]                               o_send_request,
   output logic [2:0]                               o_send_aborted_flag,
   output logic [2:0]                               o_send_lost_arbitration_flag,
   output logic [2:0]                               o_send_error_flag,
   output canmb_pkg::canmb_msg_t                    o_receive_buffer_0,
   output canmb_pkg::canmb_msg_t                    o_receive_buffer_1,
   output logic [15:0]                              o_interrupt_status_reg,
   output logic [7:0]                               o_receive_error_count,
   output logic [8:0]                               o_send_error_count,
   output logic                                     o_irq
);

   // Filter hit: masked identifier compare plus frame-type check.
   function automatic logic filt_hit(input canmb_pkg::canmb_msg_t m,
                                     input canmb_pkg::canmb_filt_t f,
                                     input logic [28:0] mask,
                                     input logic [1:0] mode);
      logic type_ok;
      type_ok = (mode == canmb_pkg::MODE_NOEXT_A) || (mode == canmb_pkg::MODE_NOEXT_B)
                || (f.ext_sel == m.ext);
      return type_ok && (((m.id ^ f.id) & mask) == 29'h0);
   endfunction

   // Two-entry buffer between the assembly buffer and the receive stage.
   localparam int FIFO_DEPTH_IDX = canmb_pkg::FIFO_DEP - 1;
   canmb_pkg::canmb_msg_t fifo [FIFO_DEPTH_IDX:0];
   logic          wr_ptr;
   logic          rd_ptr;
   logic [1:0]    fifo_count;
   logic [1:0]    next_fifo_count;
   wire logic     fifo_push = i_asm_valid && o_asm_ready;
   wire logic     fifo_valid = (fifo_count != 2'h0);
   wire logic     rx_take_ready = !i_init_mode;
   wire logic     fifo_pop = fifo_valid && rx_take_ready;
   wire canmb_pkg::canmb_msg_t head = fifo[rd_ptr];

   always_comb begin
      next_fifo_count = fifo_count;
      if (fifo_push && !fifo_pop) begin
         next_fifo_count = fifo_count + 2'h1;
      end else if (fifo_pop && !fifo_push) begin
         next_fifo_count = fifo_count - 2'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr      <= 1'b0;
         rd_ptr      <= 1'b0;
         fifo_count  <= 2'h0;
         o_asm_ready <= 1'b0;
      end else begin
         if (fifo_push) begin
            fifo[wr_ptr] <= i_asm_msg;
            wr_ptr       <= ~wr_ptr;
         end
         if (fifo_pop) begin
            rd_ptr <= ~rd_ptr;
         end
         fifo_count  <= next_fifo_count;
         o_asm_ready <= (next_fifo_count != 2'h2);
      end
   end

   // Acceptance decision for the message at the buffer head.
   logic [5:0] hits;
   genvar gf;
   generate
      for (gf = 0; gf < canmb_pkg::NUM_FILT; gf++) begin : g_filt
         assign hits[gf] = filt_hit(head, i_accept_filter[gf],
                                    i_accept_mask[gf >= 2], i_reception_mode_field[gf >= 2]);
      end
   endgenerate

   wire logic full0 = o_interrupt_status_reg[canmb_pkg::ST_RX0];
   wire logic full1 = o_interrupt_status_reg[canmb_pkg::ST_RX1];
   wire logic hit0  = fifo_pop && (|hits[1:0]);
   wire logic hit1  = fifo_pop && !(|hits[1:0]) && (|hits[5:2]);
   wire logic load0 = hit0 && !full0;
   wire logic spill = hit0 && full0 && i_double_buffer_enable && !full1;
   wire logic load1 = (hit1 && !full1) || spill;
   wire logic ovr0  = hit0 && full0 && !i_double_buffer_enable;
   wire logic ovr1  = (hit1 && full1) || (hit0 && full0 && i_double_buffer_enable && full1);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_receive_buffer_0 <= '0;
         o_receive_buffer_1 <= '0;
      end else begin
         if (load0) begin
            o_receive_buffer_0 <= head;
         end
         if (load1) begin
            o_receive_buffer_1 <= head;
         end
      end
   end

   // Transmit buffer storage.
   canmb_pkg::canmb_msg_t tx_buf [2:0];
   always_ff @(posedge i_clk) begin
      for (int b = 0; b < canmb_pkg::NUM_TXB; b++) begin
         if (i_tx_load[b]) begin
            tx_buf[b] <= i_tx_msg;
         end
      end
   end

   // Highest-priority pending buffer; lower index wins a tie.
   logic [1:0] pick_idx;
   logic       pick_any;
   always_comb begin
      pick_idx = 2'h0;
      pick_any = 1'b0;
      for (int b = 0; b < canmb_pkg::NUM_TXB; b++) begin
         if (o_send_request[b] && !i_send_request_clear[b] && (!pick_any
             || (i_send_priority_field[b] > i_send_priority_field[pick_idx]))) begin
            pick_idx = 2'(b);
            pick_any = 1'b1;
         end
      end
   end

   canmb_pkg::canmb_tx_state_t tx_state;
   logic [1:0] cur_idx;
   logic [2:0] abort_pend;
   logic       bus_off;
   wire logic  can_start = (tx_state == canmb_pkg::TX_IDLE) && i_bus_idle && pick_any
                           && !i_abort_all_pending && !bus_off && !i_init_mode;
   wire logic  sending = (tx_state == canmb_pkg::TX_SEND);
   wire logic  tx_fail = sending && (i_tx_lost || i_tx_bus_err);
   wire logic  tx_ok   = sending && i_tx_success && !tx_fail;
   wire logic [2:0] cur_oh = 3'h1 << cur_idx;
   wire logic [2:0] abort_now = sending ? (abort_pend | i_send_request_clear
                                  | {3{i_abort_all_pending}}) : 3'h0;

   // Aborts that may be acted on this cycle: not the active buffer unless it just failed.
   logic [2:0] abort_done;
   always_comb begin
      abort_done = (i_send_request_clear | {3{i_abort_all_pending}}) & o_send_request;
      if (sending) begin
         abort_done = abort_done & ~cur_oh;
         if (tx_fail) begin
            abort_done = abort_done | (abort_now & cur_oh);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_state                     <= canmb_pkg::TX_IDLE;
         cur_idx                      <= 2'h0;
         abort_pend                   <= 3'h0;
         o_tx_start                   <= 1'b0;
         o_tx_msg                     <= '0;
         o_send_request               <= 3'h0;
         o_send_aborted_flag          <= 3'h0;
         o_send_lost_arbitration_flag <= 3'h0;
         o_send_error_flag            <= 3'h0;
      end else begin
         o_tx_start <= can_start;
         if (can_start) begin
            tx_state   <= canmb_pkg::TX_SEND;
            cur_idx    <= pick_idx;
            o_tx_msg   <= tx_buf[pick_idx];
            abort_pend <= 3'h0;
         end else if (sending) begin
            abort_pend <= abort_now & cur_oh;
            if (tx_ok || tx_fail) begin
               tx_state <= canmb_pkg::TX_IDLE;
            end
         end
         for (int b = 0; b < canmb_pkg::NUM_TXB; b++) begin
            if (i_send_request_set[b] && !(sending && cur_oh[b])) begin
               o_send_request[b]               <= 1'b1;
               o_send_aborted_flag[b]          <= 1'b0;
               o_send_lost_arbitration_flag[b] <= 1'b0;
               o_send_error_flag[b]            <= 1'b0;
            end else if (abort_done[b]) begin
               o_send_request[b]      <= 1'b0;
               o_send_aborted_flag[b] <= 1'b1;
            end else if (tx_ok && cur_oh[b]) begin
               o_send_request[b] <= 1'b0;
            end
            if (tx_fail && cur_oh[b]) begin
               if (i_tx_bus_err) begin
                  o_send_error_flag[b] <= 1'b1;
               end
               if (i_tx_lost) begin
                  o_send_lost_arbitration_flag[b] <= 1'b1;
               end
            end
         end
      end
   end

   // Error counters.
   wire logic rx_err = i_rx_crc_err || i_rx_stuff_err || i_rx_invalid_err;
   wire logic tx_err = i_tx_ack_err || i_tx_form_err || i_tx_bit_err;
   logic [7:0] next_rec;
   logic [8:0] next_tec;
   always_comb begin
      next_rec = o_receive_error_count;
      next_tec = o_send_error_count;
      if (i_init_mode || i_bus_off_recover) begin
         next_rec = 8'h00;
         next_tec = 9'h000;
      end else begin
         if (rx_err && (o_receive_error_count != canmb_pkg::REC_MAX)) begin
            next_rec = o_receive_error_count + 8'h01;
         end
         if (tx_err && (o_send_error_count != canmb_pkg::TEC_MAX)) begin
            next_tec = o_send_error_count + 9'h001;
         end
      end
   end

   assign bus_off = o_interrupt_status_reg[canmb_pkg::ST_BUSOFF];

   // Level indications derived from the counters.
   logic [15:0] level_next;
   always_comb begin
      level_next                         = 16'h0000;
      level_next[canmb_pkg::ST_RXWARN]   = (next_rec >= canmb_pkg::REC_WARN);
      level_next[canmb_pkg::ST_RXPASS]   = (next_rec > canmb_pkg::REC_PASSIVE);
      level_next[canmb_pkg::ST_TXWARN]   = (next_tec > canmb_pkg::TEC_WARN);
      level_next[canmb_pkg::ST_TXPASS]   = (next_tec > canmb_pkg::TEC_PASSIVE);
      level_next[canmb_pkg::ST_BUSOFF]   = (next_tec > canmb_pkg::TEC_BUSOFF);
   end

   // Sticky events; a set in the same cycle as a clear wins.
   logic [15:0] st_set;
   always_comb begin
      st_set                         = 16'h0000;
      st_set[canmb_pkg::ST_RX0]      = load0;
      st_set[canmb_pkg::ST_RX1]      = load1;
      st_set[canmb_pkg::ST_TX0 +: 3] = tx_ok ? cur_oh : 3'h0;
      st_set[canmb_pkg::ST_RX0OVR]   = ovr0;
      st_set[canmb_pkg::ST_RX1OVR]   = ovr1;
      st_set[canmb_pkg::ST_INVALID]  = rx_err;
      st_set[canmb_pkg::ST_WAKE]     = i_wake_bus || i_wake_sleep;
      st_set[canmb_pkg::ST_ERR]      = ovr0 || ovr1 || rx_err || (tx_fail && i_tx_bus_err)
         || (level_next[canmb_pkg::ST_RXWARN]
             && !o_interrupt_status_reg[canmb_pkg::ST_RXWARN])
         || (level_next[canmb_pkg::ST_TXWARN]
             && !o_interrupt_status_reg[canmb_pkg::ST_TXWARN]);
   end

   wire logic [15:0] next_status =
      (((o_interrupt_status_reg & ~i_status_clear) | st_set) & ~canmb_pkg::LEVEL_BITS)
      | level_next;

   wire logic next_irq =
      (|(next_status[1:0] & i_message_received_irq_enable))
      || (i_send_irq_enable && (|next_status[canmb_pkg::ST_TX0 +: 3]))
      || (i_error_irq_enable && next_status[canmb_pkg::ST_ERR])
      || (i_wake_irq_enable && next_status[canmb_pkg::ST_WAKE]);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_interrupt_status_reg <= canmb_pkg::STATUS_RESET;
         o_receive_error_count  <= 8'h00;
         o_send_error_count     <= 9'h000;
         o_tx_drive_en          <= 1'b0;
         o_irq                  <= 1'b0;
      end else begin
         o_interrupt_status_reg <= next_status;
         o_receive_error_count  <= next_rec;
         o_send_error_count     <= next_tec;
         o_tx_drive_en          <= !level_next[canmb_pkg::ST_BUSOFF] && !i_init_mode;
         o_irq                  <= next_irq;
      end
   end

endmodule

//--- hdl/canmb_pkg.sv
// Constants and types shared by the CAN message buffering block.
// How it works
// - Assembly buffer plus two visible receive buffers.
// - Landing sets received flag; software clears it.
// - Filters 0-1 to buffer 0, 2-5 to 1.
// - Frame type must match filter extended select.
// - Mode 01 or 10 ignores extended select.
// - Mask bit zero means identifier bit matches.
// - Accepted into full buffer: overrun, error, discard.
// - Without double buffering, buffers work independently.
// - Double buffering spills buffer 0 into buffer 1.
// - Receive errors count; warning 96, passive above 127.
// - Receive interrupt right after end of frame.
// - Errors in last message set invalid flag.
// - Wake from disable or sleep raises interrupt.
// - Three transmit buffers of full message each.
// - Two-bit priority, 11 highest, 00 lowest.
// - Setting request clears aborted, lost, error flags; a set for the buffer being sent is ignored here.
// - Idle bus starts highest priority pending buffer.
// - Success clears request and may interrupt.
// - Failure keeps request; error or lost flag.
// - Clear request or abort-all aborts, no free flag.
// - Transmit errors count; warning, passive, bus-off thresholds.
// - Free flag shows which transmit buffer is available; no free flag here, a low o_send_request bit marks it.
// - Initialization clears both counters, keeps flags.
package canmb_pkg;

   localparam int NUM_FILT = 6;
   localparam int NUM_TXB  = 3;
   localparam int FIFO_DEP = 2;

   // Interrupt status bit positions.
   localparam int ST_RX0     = 0;
   localparam int ST_RX1     = 1;
   localparam int ST_TX0     = 2;
   localparam int ST_ERR     = 5;
   localparam int ST_WAKE    = 6;
   localparam int ST_INVALID = 7;
   localparam int ST_RXWARN  = 9;
   localparam int ST_TXWARN  = 10;
   localparam int ST_RXPASS  = 11;
   localparam int ST_TXPASS  = 12;
   localparam int ST_BUSOFF  = 13;
   localparam int ST_RX1OVR  = 14;
   localparam int ST_RX0OVR  = 15;

   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] LEVEL_BITS   = 16'h3E00;

   localparam logic [7:0] REC_WARN    = 8'h60;
   localparam logic [7:0] REC_PASSIVE = 8'h7F;
   localparam logic [7:0] REC_MAX     = 8'hFF;
   localparam logic [8:0] TEC_WARN    = 9'h060;
   localparam logic [8:0] TEC_PASSIVE = 9'h07F;
   localparam logic [8:0] TEC_BUSOFF  = 9'h0FF;
   localparam logic [8:0] TEC_MAX     = 9'h100;

   localparam logic [1:0] MODE_NOEXT_A = 2'h1;
   localparam logic [1:0] MODE_NOEXT_B = 2'h2;

   typedef struct packed {
      logic        ext;
      logic [28:0] id;
      logic [3:0]  dlc;
      logic [63:0] data;
   } canmb_msg_t;

   typedef struct packed {
      logic        ext_sel;
      logic [28:0] id;
   } canmb_filt_t;

   typedef enum logic {TX_IDLE, TX_SEND} canmb_tx_state_t;

endpackage

//--- test/canmb_top_monitor.sv
// Port-level assertions for the CAN message buffering top.
`timescale 1ns/1ns
module canmb_top_monitor (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_init_mode,
   input wire logic        i_rx_crc_err,
   input wire logic        i_wake_bus,
   input wire logic        i_bus_off_recover,
   input wire logic [2:0]  i_send_request_set,
   input wire logic [2:0]  i_send_request_clear,
   input wire logic        i_abort_all_pending,
   input wire logic        o_tx_start,
   input wire logic        o_tx_drive_en,
   input wire logic [2:0]  o_send_request,
   input wire logic [2:0]  o_send_aborted_flag,
   input wire logic [15:0] o_interrupt_status_reg,
   input wire logic [7:0]  o_receive_error_count,
   input wire logic [8:0]  o_send_error_count
);
   wire [15:0] st = o_interrupt_status_reg;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_rx_inc;
      i_rx_crc_err && !i_init_mode && !i_bus_off_recover && o_receive_error_count != 8'hFF
      |=> o_receive_error_count == $past(o_receive_error_count) + 8'h01;
   endproperty
   a_rx_inc: assert property (p_rx_inc) else $error("Receive count did not step");
   property p_rx_warn; o_receive_error_count >= 8'h60 |-> st[9]; endproperty
   a_rx_warn: assert property (p_rx_warn) else $error("Receive warning missing");
   property p_rx_pass; o_receive_error_count > 8'h7F |-> st[11]; endproperty
   a_rx_pass: assert property (p_rx_pass) else $error("Receive passive missing");
   property p_tx_warn; o_send_error_count > 9'h060 |-> st[10]; endproperty
   a_tx_warn: assert property (p_tx_warn) else $error("Send warning missing");
   property p_bus_off; st[13] && $past(st[13]) |-> !o_tx_drive_en && !o_tx_start; endproperty
   a_bus_off: assert property (p_bus_off) else $error("Bus driven while off");
   property p_init;
      i_init_mode |=> o_receive_error_count == 8'h00 && o_send_error_count == 9'h000
      && !o_tx_drive_en;
   endproperty
   a_init: assert property (p_init) else $error("Init did not clear counters");
   property p_ovr; $rose(st[15]) |-> st[5]; endproperty
   a_ovr: assert property (p_ovr) else $error("Overrun without error summary");
   property p_req_set;
      i_send_request_set[0] && !o_send_request[0] && !i_send_request_clear[0]
      && !i_abort_all_pending |=> o_send_request[0] && !o_send_aborted_flag[0];
   endproperty
   a_req_set: assert property (p_req_set) else $error("Request set kept aborted flag");
   property p_start; o_tx_start |=> !o_tx_start; endproperty
   a_start: assert property (p_start) else $error("Start pulse too long");
   property p_wake; i_wake_bus |=> st[6]; endproperty
   a_wake: assert property (p_wake) else $error("Wake flag missing");
   c_start: cover property (o_tx_start);
   c_ovr: cover property ($rose(st[15]));
   c_off: cover property (st[13]);
endmodule
bind canmb_top canmb_top_monitor u_mon (.i_clk, .i_rst, .i_init_mode, .i_rx_crc_err,
   .i_wake_bus, .i_bus_off_recover, .i_send_request_set, .i_send_request_clear,
   .i_abort_all_pending, .o_tx_start, .o_tx_drive_en, .o_send_request, .o_send_aborted_flag,
   .o_interrupt_status_reg, .o_receive_error_count, .o_send_error_count);

//--- test/canmb_bus_model.sv
// Behavioural model of the other bus nodes answering each frame start with an outcome.
`timescale 1ns/1ns
module canmb_bus_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_idle_en,
   input  wire logic [1:0] i_outcome,
   input  wire logic [3:0] i_delay,
   input  wire logic       i_tx_start,
   output logic            o_bus_idle,
   output logic            o_success,
   output logic            o_lost,
   output logic            o_bus_err
);
   logic       busy;
   logic [3:0] cnt;
   // The bus stays occupied from the start pulse until the outcome is given.
   assign o_bus_idle = i_idle_en && !busy && !i_tx_start;
   always @(posedge i_clk) begin
      o_success <= 1'b0;
      o_lost    <= 1'b0;
      o_bus_err <= 1'b0;
      if (i_rst) begin
         busy <= 1'b0;
         cnt  <= 4'h0;
      end else if (i_tx_start) begin
         busy <= 1'b1;
         cnt  <= i_delay;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         busy      <= 1'b0;
         o_success <= (i_outcome == 2'h0);
         o_lost    <= (i_outcome == 2'h1);
         o_bus_err <= (i_outcome == 2'h2);
      end
   end
endmodule

//--- test/canmb_top_test.sv
// Self-checking bench for the CAN message buffering top.
`timescale 1ns/1ns
module canmb_top_test;
   logic i_clk = 1'b0, i_rst = 1'b1, i_init_mode = 1'b0, i_asm_valid = 1'b0;
   logic i_rx_crc_err = 1'b0, i_rx_stuff_err = 1'b0, i_rx_invalid_err = 1'b0;
   logic i_wake_bus = 1'b0, i_wake_sleep = 1'b0, i_double_buffer_enable = 1'b0;
   logic i_send_irq_enable = 1'b1, i_error_irq_enable = 1'b1, i_wake_irq_enable = 1'b1;
   logic i_abort_all_pending = 1'b0, i_bus_off_recover = 1'b0, idle_en = 1'b0;
   logic i_tx_ack_err = 1'b0, i_tx_form_err = 1'b0, i_tx_bit_err = 1'b0;
   logic i_bus_idle, i_tx_success, i_tx_lost, i_tx_bus_err, o_asm_ready, o_tx_start;
   logic o_tx_drive_en, o_irq;
   logic [1:0] i_message_received_irq_enable = 2'h3, outcome = 2'h0;
   logic [15:0] i_status_clear = 16'h0000, o_interrupt_status_reg;
   logic [2:0] i_tx_load = 3'h0, i_send_request_set = 3'h0, i_send_request_clear = 3'h0;
   logic [2:0] o_send_request, o_send_aborted_flag, o_send_lost_arbitration_flag;
   logic [2:0] o_send_error_flag;
   logic [2:0][1:0] i_send_priority_field = {2'h2, 2'h3, 2'h1};
   logic [1:0][1:0] i_reception_mode_field = '0;
   logic [1:0][28:0] i_accept_mask = {29'h1FFFFF00, 29'h1FFFFFFF};
   canmb_pkg::canmb_filt_t [5:0] i_accept_filter;
   canmb_pkg::canmb_msg_t i_asm_msg = '0, i_tx_msg = '0, o_tx_msg, m, a;
   canmb_pkg::canmb_msg_t o_receive_buffer_0, o_receive_buffer_1, tb [3];
   logic [7:0]  o_receive_error_count;
   logic [8:0]  o_send_error_count;
   logic [31:0] rnd = 32'hEE280485;
   int          errors = 0, num_checks = 0, cycles = 0;
   int          a_ord [3] = '{1, 2, 0};
   wire  [15:0] st = o_interrupt_status_reg;
   // Filters 3..5 hold an extended identifier that no stimulus ever uses.
   assign i_accept_filter = {{3{1'b1, 29'h1000000}}, {1'b0, 29'h200}, {1'b1, 29'h1ABCDEF},
      {1'b0, 29'h100}};
   always #25 i_clk = ~i_clk;
   canmb_top uut (.*);
   canmb_bus_model peer (.i_clk, .i_rst, .i_idle_en(idle_en), .i_outcome(outcome),
      .i_delay({1'b0, rnd[2:0]}), .i_tx_start(o_tx_start), .o_bus_idle(i_bus_idle),
      .o_success(i_tx_success), .o_lost(i_tx_lost), .o_bus_err(i_tx_bus_err));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic canmb_pkg::canmb_msg_t mk(input logic x, input logic [28:0] id);
      rnd = lfsr(rnd);
      return '{x, id, 4'h8, {rnd, ~rnd}};
   endfunction
   task automatic chk(input string n, input logic [195:0] got, input logic [195:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", n, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic clr;
      i_status_clear = 16'hFFFF;
      cyc(1);
      i_status_clear = 16'h0000;
      cyc(1);
   endtask
   // Holds the word until ready, seen before an edge, shows it was taken.
   task automatic rx(input canmb_pkg::canmb_msg_t w);
      int k = 0;
      i_asm_msg = w;
      i_asm_valid = 1'b1;
      while (o_asm_ready !== 1'b1 && k < 50) begin k++; cyc(1); end
      cyc(1);
      i_asm_valid = 1'b0;
      cyc(2);
   endtask
   task automatic wait_start;
      int k = 0;
      while (o_tx_start !== 1'b1 && k < 100) begin k++; cyc(1); end
      chk("tx_start", o_tx_start, 1'b1);
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      cyc(8);
      i_rst = 1'b0;
      cyc(2);
      m = mk(1'b0, 29'h100);
      rx(m);
      chk("rb0", o_receive_buffer_0, m);
      chk("rx0_irq", {st[0], o_irq}, 2'h3);
      a = mk(1'b0, {21'h000002, rnd[7:0]});
      rx(a);
      chk("rb1", {o_receive_buffer_1, st[1]}, {a, 1'b1});
      rx(mk(1'b0, 29'h100));
      chk("rb0_kept", o_receive_buffer_0, m);
      chk("ovr", {st[15:14], st[5]}, 3'h5);
      clr;
      rx(mk(1'b1, 29'h100));
      chk("ext_drop", st[1:0], 2'h0);
      for (int j = 0; j < 3; j++) begin
         i_reception_mode_field[0] = j[1:0];
         rx(mk(1'b1, (j == 0) ? 29'h1ABCDEF : 29'h100));
         chk("ext_mode", st[0], 1'b1);
         clr;
      end
      i_reception_mode_field[0] = 2'h0;
      i_double_buffer_enable = 1'b1;
      rx(mk(1'b0, 29'h100));
      m = mk(1'b0, 29'h100);
      rx(m);
      chk("spill", {o_receive_buffer_1, st[15]}, {m, 1'b0});
      rx(mk(1'b0, 29'h100));
      chk("lost_both", st[15:14], 2'h1);
      clr;
      i_double_buffer_enable = 1'b0;
      i_init_mode = 1'b1;
      m = mk(1'b0, 29'h100);
      rx(m);
      a = mk(1'b0, {21'h000002, rnd[7:0]});
      rx(a);
      chk("full_stall", o_asm_ready, 1'b0);
      i_init_mode = 1'b0;
      cyc(4);
      chk("drained", {o_receive_buffer_0, o_receive_buffer_1}, {m, a});
      clr;
      for (int i = 1; i <= 128; i++) begin
         {i_rx_crc_err, i_rx_stuff_err, i_rx_invalid_err} = 3'h1 << (i % 3);
         cyc(1);
         {i_rx_crc_err, i_rx_stuff_err, i_rx_invalid_err} = 3'h0;
         cyc(1);
         if (i == 95 || i == 96) chk("rx_warn", st[9], i == 96);
         if (i == 127 || i == 128) chk("rx_pass", st[11], i == 128);
      end
      chk("invalid", {st[7], st[5], o_receive_error_count}, {2'h3, 8'h80});
      i_init_mode = 1'b1;
      cyc(2);
      i_init_mode = 1'b0;
      chk("init", {st[7], o_receive_error_count}, {1'b1, 8'h00});
      for (int w = 0; w < 2; w++) begin
         clr;
         {i_wake_sleep, i_wake_bus} = 2'h1 << w;
         cyc(1);
         {i_wake_sleep, i_wake_bus} = 2'h0;
         cyc(1);
         chk("wake", st[6], 1'b1);
      end
      for (int b = 0; b < 3; b++) begin
         tb[b] = mk(b[0], {rnd[28:0]});
         i_tx_msg = tb[b];
         i_tx_load = 3'h1 << b;
         cyc(1);
      end
      i_tx_load = 3'h0;
      clr;
      i_send_request_set = 3'h7;
      cyc(1);
      i_send_request_set = 3'h0;
      foreach (a_ord[n]) begin
         idle_en = 1'b1;
         wait_start;
         idle_en = 1'b0;
         chk("tx_msg", o_tx_msg, tb[a_ord[n]]);
         cyc(12);
         chk("tx_done", {o_send_request[a_ord[n]], st[2 + a_ord[n]]}, 2'h1);
      end
      clr;
      for (int k = 0; k < 3; k++) begin
         i_send_request_set = 3'h1;
         cyc(1);
         i_send_request_set = 3'h0;
         cyc(1);
         chk("req_clr", o_send_aborted_flag[0], 1'b0);
         outcome = k[1:0];
         if (k == 0) i_send_request_clear = 3'h1;
         else idle_en = 1'b1;
         if (k != 0) wait_start;
         cyc(1);
         idle_en = 1'b0;
         i_send_request_clear = 3'h0;
         cyc(12);
         if (k == 0) chk("abort", {o_send_request[0], o_send_aborted_flag[0], st[2]}, 3'h2);
         if (k == 1) chk("lost", {o_send_request[0], o_send_lost_arbitration_flag[0]}, 2'h3);
         if (k == 2) chk("bus_err", {o_send_request[0], o_send_error_flag[0], st[5]}, 3'h7);
      end
      i_abort_all_pending = 1'b1;
      cyc(1);
      i_abort_all_pending = 1'b0;
      cyc(2);
      chk("abort_all", {o_send_request[0], o_send_aborted_flag[0]}, 2'h1);
      for (int i = 1; i <= 256; i++) begin
         {i_tx_ack_err, i_tx_form_err, i_tx_bit_err} = 3'h1 << (i % 3);
         cyc(1);
         {i_tx_ack_err, i_tx_form_err, i_tx_bit_err} = 3'h0;
         cyc(1);
         if (i == 96 || i == 97) chk("tx_warn", st[10], i == 97);
         if (i == 127 || i == 128) chk("tx_pass", st[12], i == 128);
         if (i == 255 || i == 256) chk("bus_off", st[13], i == 256);
      end
      i_send_request_set = 3'h2;
      idle_en = 1'b1;
      cyc(10);
      chk("off_hold", {o_tx_drive_en, o_send_request[1]}, 2'h1);
      idle_en = 1'b0;
      i_send_request_set = 3'h0;
      i_bus_off_recover = 1'b1;
      cyc(1);
      i_bus_off_recover = 1'b0;
      cyc(2);
      chk("recover", o_send_error_count, 9'h000);
      report_and_stop;
   end
endmodule
